// ---- logic/ncs_pkg.sv ----
/*
 * ncs_pkg: shared constants of the contactless command sequencer:
 * bus offsets, register fields, command codes, identity buffer layout,
 * start-up count, crc presets and the sequencer state encoding.
 * Assumes a 32-bit classic wishbone register bus with byte addresses.
 */
`default_nettype none

package ncs_pkg;

	// register byte offsets, one aligned word each
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_FIFO = 8'h04;
	localparam logic [7:0] OFF_LEVEL = 8'h08;
	localparam logic [7:0] OFF_EVENT = 8'h0c;
	localparam logic [7:0] OFF_FRAMING = 8'h10;
	localparam logic [7:0] OFF_MODE = 8'h14;
	localparam logic [7:0] OFF_CRC = 8'h18;
	localparam logic [7:0] OFF_TEST = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;

	// field positions
	localparam int CMD_PD_BIT = 4;
	localparam int LEVEL_FLUSH_BIT = 7;
	localparam int EVT_IDLE_BIT = 4;
	localparam int FRM_LAUNCH_BIT = 7;
	localparam int MODE_DEPTH_BIT = 2;
	localparam int MODE_CARD_BIT = 3;

	// command codes
	localparam logic [3:0] CMD_IDLE = 4'h0;
	localparam logic [3:0] CMD_CONFIG = 4'h1;
	localparam logic [3:0] CMD_RANDOM = 4'h2;
	localparam logic [3:0] CMD_CRC = 4'h3;
	localparam logic [3:0] CMD_TRANSMIT = 4'h4;
	localparam logic [3:0] CMD_CAL = 4'h5;
	localparam logic [3:0] CMD_ADC = 4'h6;
	localparam logic [3:0] CMD_KEEP = 4'h7;
	localparam logic [3:0] CMD_RECEIVE = 4'h8;
	localparam logic [3:0] CMD_TRX = 4'hc;
	localparam logic [3:0] CMD_AUTO = 4'hd;
	localparam logic [3:0] CMD_SRST = 4'hf;

	// identity buffer layout (byte indices)
	localparam int ID_LEN = 25;
	localparam logic [4:0] ID_LAST = 5'h18;
	localparam logic [4:0] ID_NFCID1_0 = 5'h02;
	localparam logic [4:0] ID_NFCID2_0 = 5'h08;
	localparam logic [4:0] ID_NFCID3 = 5'h18;
	localparam logic [7:0] ID_NFCID1_FIXED = 8'h08;
	localparam logic [4:0] RAND_LAST = 5'h09;
	localparam logic [4:0] RAND_N1_END = 5'h03;
	localparam logic [4:0] RAND_N2_END = 5'h09;

	// self test
	localparam logic [3:0] SELFTEST_CODE = 4'h9;
	localparam logic [4:0] SELFTEST_LAST = 5'h07;
	localparam logic [15:0] LFSR_SEED = 16'hace1;

	// clocks to wait once the oscillator is stable
	localparam int STARTUP_CLKS = 1024;

	// crc coprocessor
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_PRE0 = 16'h0000;
	localparam logic [15:0] CRC_PRE1 = 16'h6363;
	localparam logic [15:0] CRC_PRE2 = 16'ha671;
	localparam logic [15:0] CRC_PRE3 = 16'hffff;

	// sequencer states, gray coded along the usual path
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_CFG_IN = 4'h1,
		ST_CFG_OUT = 4'h3,
		ST_RAND = 4'h2,
		ST_CRC = 4'h6,
		ST_SELFTEST = 4'h7,
		ST_TX = 4'h5,
		ST_CAL = 4'h4,
		ST_ADC = 4'hc,
		ST_RX = 4'hd,
		ST_TRX_WAIT = 4'hf,
		ST_TRX_TX = 4'he,
		ST_TRX_RX = 4'ha,
		ST_AUTO = 4'hb,
		ST_SRST = 4'h9
	} ncs_state_t;

endpackage : ncs_pkg

`default_nettype wire

// ---- logic/ncs_crc_if.sv ----
/*
 * ncs_crc_if: link between the sequencer and its crc coprocessor.
 * Assumes both ends run on the same clock; all fields are levels
 * except init and feed, which are one-cycle strobes.
 */
`timescale 1ns/1ps
`default_nettype none

interface ncs_crc_if;
	logic init;
	logic [15:0] preset;
	logic feed;
	logic [7:0] data;
	logic [15:0] result;
	modport engine(input init, input preset, input feed, input data,
		output result);
	modport ctrl(output init, output preset, output feed, output data,
		input result);
endinterface : ncs_crc_if

`default_nettype wire

// ---- logic/ncs_crc_engine.sv ----
/*
 * ncs_crc_engine: byte-wide crc-16 coprocessor for the sequencer.
 * Assumes init and feed never come in the same cycle from the
 * sequencer; init wins if they do.
 */
`timescale 1ns/1ps
`default_nettype none

module ncs_crc_engine (
	input wire logic clk_i,
	input wire logic rst_i,
	ncs_crc_if.engine crc
);

	logic [15:0] crc_r;
	logic [15:0] crc_nxt;

	// one byte, msb first, through the polynomial
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] v;
		v = c;
		for (int i = 7; i >= 0; i--) begin
			if (v[15] ^ d[i]) begin
				v = {v[14:0], 1'b0} ^ ncs_pkg::CRC_POLY;
			end else begin
				v = {v[14:0], 1'b0};
			end
		end
		return v;
	endfunction : crc_byte

	assign crc_nxt = crc_byte(crc_r, crc.data);
	assign crc.result = crc_r;

	// preset at start, then accumulate every fed byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crc_r <= ncs_pkg::CRC_PRE0;
		end else if (crc.init) begin
			crc_r <= crc.preset;
		end else if (crc.feed) begin
			crc_r <= crc_nxt;
		end
	end

endmodule : ncs_crc_engine

`default_nettype wire

// ---- logic/ncs_command_sequencer.sv ----
/*
 * ncs_command_sequencer: command state machine of the contactless
 * front-end with its byte fifo, identity buffer and register file.
 * Assumes a classic wishbone master, a tx sink and rx source on clk_i,
 * calibration and adc helpers on clk_i, and clk_stable_i from a pin.
 */
// Local design decisions: the Wishbone interface to the registers and the address map.
// Functional notes
// - host writes code; data comes through fifo
// - streams start at once; transceive awaits launch
// - fixed-argument commands wait for all bytes
// - starting a command never clears fifo, except soft reset
// - new command code aborts the running one
// - decode idle, configure, random id, crc
// - decode transmit, calibrate, rf level, keep
// - decode receive, transceive, auto polling, reset
// - keep code leaves command, updates other bits
// - idle enters idle and ends at once
// - configure loads 25 identity bytes in order
// - first nfcid1 byte forced, check byte computed
// - configure on empty fifo reads buffer back
// - identity buffer survives reset; configure self-ends
// - random id replaces ten buffer bytes, ends
// - crc eats fifo bytes, keeps running when empty
// - crc preset loaded at start; host ends it
// - self test selected: crc start pushes result
// - transmit drains fifo, ends when empty
// - calibrate coarse only, or coarse then fine
// - rf level command starts the adc
// - wait 1024 clocks after clock stable
// - command end sets idle event flag
// - software reset clears registers and fifo, keeps identity and crc
`timescale 1ns/1ps
`default_nettype none

module ncs_command_sequencer #(
	parameter int FIFO_DEPTH = 64
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic clk_stable_i,
	output logic [7:0] tx_byte_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic rx_enable_o,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_valid_i,
	input wire logic rx_end_i,
	output logic cal_start_o,
	output logic cal_fine_o,
	input wire logic cal_done_i,
	output logic adc_start_o,
	input wire logic adc_done_i,
	output logic power_down_o
);

	localparam int PW = $clog2(FIFO_DEPTH) + 1;

	ncs_pkg::ncs_state_t state_r, state_nxt, start_st;
	logic [4:0] idx_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic pd_r, pd_exit_r, launch_r, idle_flag_r, ready_r;
	logic [3:0] mode_r, test_r;
	logic [10:0] cnt_r;
	logic stab1_r, stab2_r, stab3_r, stable_r;
	logic [15:0] lfsr_r;
	logic [7:0] tx_byte_r;
	logic tx_valid_r, rx_en_r, cal_start_r, cal_fine_r, adc_start_r;
	logic [7:0] fifo_mem [FIFO_DEPTH];
	logic [PW-1:0] wp_r, rp_r;
	logic [7:0] id_mem [ncs_pkg::ID_LEN];

	ncs_crc_if crc_link();

	ncs_crc_engine u_crc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.crc(crc_link.engine)
	);

	// address match on word index
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a[7:2] == o[7:2];
	endfunction : hit

	// code shown in the command field for each state
	function automatic logic [3:0] code_of(input ncs_pkg::ncs_state_t s);
		case (s)
			ncs_pkg::ST_CFG_IN, ncs_pkg::ST_CFG_OUT: return ncs_pkg::CMD_CONFIG;
			ncs_pkg::ST_RAND: return ncs_pkg::CMD_RANDOM;
			ncs_pkg::ST_CRC, ncs_pkg::ST_SELFTEST: return ncs_pkg::CMD_CRC;
			ncs_pkg::ST_TX: return ncs_pkg::CMD_TRANSMIT;
			ncs_pkg::ST_CAL: return ncs_pkg::CMD_CAL;
			ncs_pkg::ST_ADC: return ncs_pkg::CMD_ADC;
			ncs_pkg::ST_RX: return ncs_pkg::CMD_RECEIVE;
			ncs_pkg::ST_TRX_WAIT, ncs_pkg::ST_TRX_TX,
			ncs_pkg::ST_TRX_RX: return ncs_pkg::CMD_TRX;
			ncs_pkg::ST_AUTO: return ncs_pkg::CMD_AUTO;
			ncs_pkg::ST_SRST: return ncs_pkg::CMD_SRST;
			default: return ncs_pkg::CMD_IDLE;
		endcase
	endfunction : code_of

	// random bytes land on nfcid1, nfcid2 and nfcid3 slots
	function automatic logic [4:0] rand_slot(input logic [4:0] k);
		if (k < ncs_pkg::RAND_N1_END) begin
			return ncs_pkg::ID_NFCID1_0 + k;
		end else if (k < ncs_pkg::RAND_N2_END) begin
			return ncs_pkg::ID_NFCID2_0 + k - ncs_pkg::RAND_N1_END;
		end
		return ncs_pkg::ID_NFCID3;
	endfunction : rand_slot

	// bus decode: ack one cycle after the request, writes at ack edge
	wire wb_req = wb_cyc_i & wb_stb_i;
	wire wb_issue = wb_req & ~ack_r & ready_r;
	wire wb_commit = wb_req & ack_r & wb_we_i & wb_sel_i[0];
	wire cmd_wr = wb_commit & hit(wb_adr_i, ncs_pkg::OFF_CMD);
	wire [3:0] wr_code = wb_dat_i[3:0];
	wire chg = cmd_wr & (wr_code != ncs_pkg::CMD_KEEP);
	wire host_push = wb_commit & hit(wb_adr_i, ncs_pkg::OFF_FIFO);
	wire host_pop = wb_issue & ~wb_we_i & hit(wb_adr_i, ncs_pkg::OFF_FIFO);
	wire flush = wb_commit & hit(wb_adr_i, ncs_pkg::OFF_LEVEL) &
		wb_dat_i[ncs_pkg::LEVEL_FLUSH_BIT];

	// fifo bookkeeping
	wire [PW-1:0] fifo_cnt = wp_r - rp_r;
	wire fifo_empty = (fifo_cnt == '0);
	wire fifo_full = (fifo_cnt == PW'(FIFO_DEPTH));
	wire [7:0] fifo_head = fifo_mem[rp_r[PW-2:0]];
	wire st_txing = (state_r == ncs_pkg::ST_TX) |
		(state_r == ncs_pkg::ST_TRX_TX);
	wire st_rxing = (state_r == ncs_pkg::ST_RX) |
		(state_r == ncs_pkg::ST_TRX_RX) | (state_r == ncs_pkg::ST_AUTO);

	// device side of the fifo; idles in a command-write cycle
	wire dev_pop = ~cmd_wr & ~host_pop & ~fifo_empty & (
		(state_r == ncs_pkg::ST_CFG_IN) |
		(state_r == ncs_pkg::ST_CRC) |
		(st_txing & (~tx_valid_r | tx_ready_i)));
	wire dev_push = ~cmd_wr & ~host_push & ~fifo_full & (
		(state_r == ncs_pkg::ST_CFG_OUT) |
		(state_r == ncs_pkg::ST_SELFTEST) |
		(st_rxing & rx_valid_i));
	wire [7:0] dev_data = (state_r == ncs_pkg::ST_CFG_OUT) ? id_mem[idx_r] :
		(state_r == ncs_pkg::ST_SELFTEST) ? lfsr_r[7:0] : rx_byte_i;
	wire do_push = (host_push & ~fifo_full) | dev_push;
	wire do_pop = (host_pop & ~fifo_empty) | dev_pop;
	wire [7:0] push_data = host_push ? wb_dat_i[7:0] : dev_data;

	// natural end of the running command
	wire fin = ~cmd_wr & (
		((state_r == ncs_pkg::ST_CFG_IN) & dev_pop &
			(idx_r == ncs_pkg::ID_LAST)) |
		((state_r == ncs_pkg::ST_CFG_OUT) & dev_push &
			(idx_r == ncs_pkg::ID_LAST)) |
		((state_r == ncs_pkg::ST_RAND) &
			(idx_r == ncs_pkg::RAND_LAST)) |
		((state_r == ncs_pkg::ST_SELFTEST) & dev_push &
			(idx_r == ncs_pkg::SELFTEST_LAST)) |
		((state_r == ncs_pkg::ST_TX) & fifo_empty & ~tx_valid_r) |
		((state_r == ncs_pkg::ST_CAL) & cal_done_i) |
		((state_r == ncs_pkg::ST_ADC) & adc_done_i) |
		((state_r == ncs_pkg::ST_RX) & rx_end_i) |
		(state_r == ncs_pkg::ST_SRST));
	wire idle_set = fin | (cmd_wr & (wr_code == ncs_pkg::CMD_IDLE));
	wire adv = dev_pop & (state_r == ncs_pkg::ST_CFG_IN) |
		dev_push & ((state_r == ncs_pkg::ST_CFG_OUT) |
		(state_r == ncs_pkg::ST_SELFTEST)) |
		~cmd_wr & (state_r == ncs_pkg::ST_RAND);
	wire soft_rst = (state_r == ncs_pkg::ST_SRST);
	wire cnt_done = (cnt_r == 11'(ncs_pkg::STARTUP_CLKS - 1));
	wire [7:0] check_byte = id_mem[ncs_pkg::ID_NFCID1_0] ^
		id_mem[ncs_pkg::ID_NFCID1_0 + 5'h01] ^
		id_mem[ncs_pkg::ID_NFCID1_0 + 5'h02];
	wire [15:0] lfsr_nxt = {lfsr_r[14:0],
		lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};

	// crc coprocessor strobes
	assign crc_link.init = chg & (start_st == ncs_pkg::ST_CRC);
	assign crc_link.preset = (mode_r[1:0] == 2'h0) ? ncs_pkg::CRC_PRE0 :
		(mode_r[1:0] == 2'h1) ? ncs_pkg::CRC_PRE1 :
		(mode_r[1:0] == 2'h2) ? ncs_pkg::CRC_PRE2 : ncs_pkg::CRC_PRE3;
	assign crc_link.feed = dev_pop & (state_r == ncs_pkg::ST_CRC);
	assign crc_link.data = fifo_head;

	// register read mux
	wire [31:0] rd_data =
		hit(wb_adr_i, ncs_pkg::OFF_CMD) ? {27'h000_0000, pd_r,
			code_of(state_r)} :
		hit(wb_adr_i, ncs_pkg::OFF_FIFO) ? {24'h00_0000, fifo_head} :
		hit(wb_adr_i, ncs_pkg::OFF_LEVEL) ? 32'(fifo_cnt) :
		hit(wb_adr_i, ncs_pkg::OFF_EVENT) ? 32'(idle_flag_r) <<
			ncs_pkg::EVT_IDLE_BIT :
		hit(wb_adr_i, ncs_pkg::OFF_FRAMING) ? 32'(launch_r) <<
			ncs_pkg::FRM_LAUNCH_BIT :
		hit(wb_adr_i, ncs_pkg::OFF_MODE) ? {28'h000_0000, mode_r} :
		hit(wb_adr_i, ncs_pkg::OFF_CRC) ? {16'h0000, crc_link.result} :
		hit(wb_adr_i, ncs_pkg::OFF_TEST) ? {28'h000_0000, test_r} :
		hit(wb_adr_i, ncs_pkg::OFF_STATUS) ? {20'h0_0000, state_r,
			check_byte} : 32'h0000_0000;

	// state entered by a written code; unknown codes go to idle
	always_comb begin
		case (wr_code)
			ncs_pkg::CMD_CONFIG: start_st = fifo_empty ?
				ncs_pkg::ST_CFG_OUT : ncs_pkg::ST_CFG_IN;
			ncs_pkg::CMD_RANDOM: start_st = ncs_pkg::ST_RAND;
			ncs_pkg::CMD_CRC: start_st = (test_r == ncs_pkg::SELFTEST_CODE) ?
				ncs_pkg::ST_SELFTEST : ncs_pkg::ST_CRC;
			ncs_pkg::CMD_TRANSMIT: start_st = ncs_pkg::ST_TX;
			ncs_pkg::CMD_CAL: start_st = ncs_pkg::ST_CAL;
			ncs_pkg::CMD_ADC: start_st = ncs_pkg::ST_ADC;
			ncs_pkg::CMD_RECEIVE: start_st = ncs_pkg::ST_RX;
			ncs_pkg::CMD_TRX: start_st = ncs_pkg::ST_TRX_WAIT;
			ncs_pkg::CMD_AUTO: start_st = mode_r[ncs_pkg::MODE_CARD_BIT] ?
				ncs_pkg::ST_AUTO : ncs_pkg::ST_IDLE;
			ncs_pkg::CMD_SRST: start_st = ncs_pkg::ST_SRST;
			default: start_st = ncs_pkg::ST_IDLE;
		endcase
	end

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		if (chg) begin
			state_nxt = start_st;
		end else if (fin) begin
			state_nxt = ncs_pkg::ST_IDLE;
		end else begin
			case (state_r)
				ncs_pkg::ST_TRX_WAIT: if (launch_r) begin
					state_nxt = ncs_pkg::ST_TRX_TX;
				end
				ncs_pkg::ST_TRX_TX: if (fifo_empty & ~tx_valid_r) begin
					state_nxt = ncs_pkg::ST_TRX_RX;
				end
				ncs_pkg::ST_TRX_RX, ncs_pkg::ST_AUTO: if (rx_end_i) begin
					state_nxt = ncs_pkg::ST_TRX_WAIT;
				end
				default: state_nxt = state_r;
			endcase
		end
	end

	// sequencer registers and helper strobes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ncs_pkg::ST_IDLE;
			idx_r <= 5'h00;
			rx_en_r <= 1'b0;
			cal_start_r <= 1'b0;
			cal_fine_r <= 1'b0;
			adc_start_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			idx_r <= chg ? 5'h00 : (adv ? idx_r + 5'h01 : idx_r);
			rx_en_r <= (state_nxt == ncs_pkg::ST_RX) |
				(state_nxt == ncs_pkg::ST_TRX_RX) |
				(state_nxt == ncs_pkg::ST_AUTO);
			cal_start_r <= chg & (start_st == ncs_pkg::ST_CAL);
			if (chg & (start_st == ncs_pkg::ST_CAL)) begin
				cal_fine_r <= mode_r[ncs_pkg::MODE_DEPTH_BIT];
			end
			adc_start_r <= chg & (start_st == ncs_pkg::ST_ADC);
		end
	end

	// transmit holding register; an abort drops the pending byte
	always_ff @(posedge clk_i) begin
		if (rst_i | chg) begin
			tx_valid_r <= 1'b0;
			tx_byte_r <= 8'h00;
		end else if (dev_pop & st_txing) begin
			tx_valid_r <= 1'b1;
			tx_byte_r <= fifo_head;
		end else if (tx_ready_i) begin
			tx_valid_r <= 1'b0;
		end
	end

	// fifo storage, flush has priority over pops
	always_ff @(posedge clk_i) begin
		if (rst_i | soft_rst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (do_push) begin
				fifo_mem[wp_r[PW-2:0]] <= push_data;
				wp_r <= wp_r + PW'(1);
			end
			if (flush) begin
				rp_r <= do_push ? wp_r + PW'(1) : wp_r;
			end else if (do_pop) begin
				rp_r <= rp_r + PW'(1);
			end
		end
	end

	// identity buffer: no reset of any kind, so it survives both
	always_ff @(posedge clk_i) begin
		if ((state_r == ncs_pkg::ST_CFG_IN) & dev_pop) begin
			id_mem[idx_r] <= (idx_r == ncs_pkg::ID_NFCID1_0) ?
				ncs_pkg::ID_NFCID1_FIXED : fifo_head;
		end else if ((state_r == ncs_pkg::ST_RAND) & ~cmd_wr) begin
			id_mem[rand_slot(idx_r)] <= lfsr_r[7:0];
		end
	end

	// random source; reseeded for a repeatable self test
	always_ff @(posedge clk_i) begin
		if (rst_i | (chg & (start_st == ncs_pkg::ST_SELFTEST))) begin
			lfsr_r <= ncs_pkg::LFSR_SEED;
		end else begin
			lfsr_r <= lfsr_nxt;
		end
	end

	// pin synchroniser and post-stable start-up wait
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stab1_r <= 1'b0;
			stab2_r <= 1'b0;
			stab3_r <= 1'b0;
			stable_r <= 1'b0;
			cnt_r <= 11'h000;
			ready_r <= 1'b0;
		end else begin
			stab1_r <= clk_stable_i;
			stab2_r <= stab1_r;
			stab3_r <= stab2_r;
			if (stab2_r == stab3_r) begin
				stable_r <= stab3_r;
			end
			if (~stable_r | (cmd_wr & pd_r & ~wb_dat_i[ncs_pkg::CMD_PD_BIT])) begin
				cnt_r <= 11'h000;
				ready_r <= 1'b0;
			end else if (~ready_r) begin
				cnt_r <= cnt_r + 11'h001;
				ready_r <= cnt_done;
			end
		end
	end

	// host registers; soft reset clears all of them but sets the idle flag
	always_ff @(posedge clk_i) begin
		if (rst_i | soft_rst) begin
			pd_r <= 1'b0;
			pd_exit_r <= 1'b0;
			launch_r <= 1'b0;
			mode_r <= 4'h0;
			test_r <= 4'h0;
			idle_flag_r <= ~rst_i & idle_set;
		end else begin
			if (cmd_wr & wb_dat_i[ncs_pkg::CMD_PD_BIT]) begin
				pd_r <= 1'b1;
			end else if (cmd_wr & pd_r) begin
				pd_exit_r <= 1'b1;
			end else if (pd_exit_r & ~ready_r & cnt_done) begin
				pd_r <= 1'b0;
				pd_exit_r <= 1'b0;
			end
			if (wb_commit & hit(wb_adr_i, ncs_pkg::OFF_FRAMING)) begin
				launch_r <= wb_dat_i[ncs_pkg::FRM_LAUNCH_BIT];
			end else if (state_r == ncs_pkg::ST_TRX_WAIT) begin
				launch_r <= 1'b0;
			end
			if (wb_commit & hit(wb_adr_i, ncs_pkg::OFF_MODE)) begin
				mode_r <= wb_dat_i[3:0];
			end
			if (wb_commit & hit(wb_adr_i, ncs_pkg::OFF_TEST)) begin
				test_r <= wb_dat_i[3:0];
			end
			// set wins over a write-one clear
			idle_flag_r <= idle_set | idle_flag_r &
				~(wb_commit & hit(wb_adr_i, ncs_pkg::OFF_EVENT) &
				wb_dat_i[ncs_pkg::EVT_IDLE_BIT]);
		end
	end

	// bus answer registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= wb_issue;
			if (wb_issue & ~wb_we_i) begin
				dat_r <= rd_data;
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign tx_byte_o = tx_byte_r;
	assign tx_valid_o = tx_valid_r;
	assign rx_enable_o = rx_en_r;
	assign cal_start_o = cal_start_r;
	assign cal_fine_o = cal_fine_r;
	assign adc_start_o = adc_start_r;
	assign power_down_o = pd_r;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_cfg_last;
		(state_r == ncs_pkg::ST_CFG_IN) && dev_pop &&
			(idx_r == ncs_pkg::ID_LAST);
	endsequence

	a_cfg_count_end: assert property (s_cfg_last |=>
		(state_r == ncs_pkg::ST_IDLE) && idle_flag_r)
		else $error("configure did not end after last byte");
	a_cfg_fixed_byte: assert property ((state_r == ncs_pkg::ST_CFG_IN) &&
		dev_pop && (idx_r == ncs_pkg::ID_NFCID1_0) |=>
		id_mem[ncs_pkg::ID_NFCID1_0] == ncs_pkg::ID_NFCID1_FIXED)
		else $error("first nfcid1 byte not forced");
	a_cmd_abort_tx: assert property (cmd_wr &&
		(wr_code == ncs_pkg::CMD_TRANSMIT) |=>
		(state_r == ncs_pkg::ST_TX) && !tx_valid_r)
		else $error("new command did not take over");
	a_keep_holds_crc: assert property ((state_r == ncs_pkg::ST_CRC) &&
		!chg |=> state_r == ncs_pkg::ST_CRC)
		else $error("crc command left without a new code");
	a_idle_ends_now: assert property (cmd_wr &&
		(wr_code == ncs_pkg::CMD_IDLE) |=>
		(state_r == ncs_pkg::ST_IDLE) && idle_flag_r)
		else $error("idle command did not settle");
	a_fifo_kept: assert property (chg |=>
		fifo_cnt == $past(fifo_cnt))
		else $error("command start changed fifo level");
	a_tx_done: assert property ((state_r == ncs_pkg::ST_TX) && fifo_empty &&
		!tx_valid_r && !cmd_wr |=> state_r == ncs_pkg::ST_IDLE)
		else $error("transmit did not end on empty fifo");
	a_launch_gate: assert property ((state_r == ncs_pkg::ST_TRX_WAIT) &&
		!launch_r |=> !tx_valid_r)
		else $error("transceive sent before launch");
	a_ready_delay: assert property ($rose(ready_r) |->
		$past(cnt_r) == 11'(ncs_pkg::STARTUP_CLKS - 1))
		else $error("bus opened before start-up count");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule : ncs_command_sequencer

`default_nettype wire

// ---- verif/ncs_far_end.sv ----
/*
 * ncs_far_end: tx sink, rx source and analog helpers for the bench.
 * Assumes the sequencer's clock and synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module ncs_far_end (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] tx_byte_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic rx_enable_i,
	output logic [7:0] rx_byte_o,
	output logic rx_valid_o,
	output logic rx_end_o,
	input wire logic cal_start_i,
	output logic cal_done_o,
	input wire logic adc_start_i,
	output logic adc_done_o,
	output logic [7:0] tx_cnt_o,
	output logic [7:0] tx_last_o
);
	logic [7:0] tick_r;
	logic [2:0] rx_r;
	logic [3:0] cal_r;
	logic [3:0] adc_r;

	// sink stalls every other cycle so held bytes are exercised
	assign tx_ready_o = tick_r[0];
	// one byte then end; idle data keeps changing so stale data shows
	assign rx_valid_o = rx_r == 3'h3;
	assign rx_end_o = rx_r == 3'h5;
	assign rx_byte_o = rx_valid_o ? 8'h5a : tick_r;
	assign cal_done_o = cal_r[3];
	assign adc_done_o = adc_r[3];

	// helpers answer four cycles after their start strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_r <= 8'h00;
			rx_r <= 3'h0;
			cal_r <= 4'h0;
			adc_r <= 4'h0;
			tx_cnt_o <= 8'h00;
			tx_last_o <= 8'h00;
		end else begin
			tick_r <= tick_r + 8'h01;
			cal_r <= {cal_r[2:0], cal_start_i};
			adc_r <= {adc_r[2:0], adc_start_i};
			rx_r <= !rx_enable_i ? 3'h0 : rx_r + {2'h0, rx_r != 3'h7};
			if (tx_valid_i && tx_ready_o) begin
				tx_cnt_o <= tx_cnt_o + 8'h01;
				tx_last_o <= tx_byte_i;
			end
		end
	end
endmodule : ncs_far_end

`default_nettype wire

// ---- verif/test_ncs_command_sequencer.sv ----
/*
 * test_ncs_command_sequencer: wishbone-driven command tests.
 * Assumes ncs_pkg and the far-end model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module test_ncs_command_sequencer;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, clk_stable_i;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, v;
	logic wb_ack_o, tx_valid_o, tx_ready_i, rx_enable_o, rx_valid_i;
	logic rx_end_i, cal_start_o, cal_fine_o, cal_done_i, power_down_o;
	logic adc_start_o, adc_done_i;
	logic [7:0] tx_byte_o, rx_byte_i, ntx, ltx;
	logic [15:0] c;
	int errors, n_checks;

	ncs_command_sequencer dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.clk_stable_i, .tx_byte_o, .tx_valid_o, .tx_ready_i, .rx_enable_o,
		.rx_byte_i, .rx_valid_i, .rx_end_i, .cal_start_o, .cal_fine_o,
		.cal_done_i, .adc_start_o, .adc_done_i, .power_down_o);
	ncs_far_end far_u (.clk_i, .rst_i, .tx_byte_i(tx_byte_o),
		.tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
		.rx_enable_i(rx_enable_o), .rx_byte_o(rx_byte_i),
		.rx_valid_o(rx_valid_i), .rx_end_o(rx_end_i),
		.cal_start_i(cal_start_o), .cal_done_o(cal_done_i),
		.adc_start_i(adc_start_o), .adc_done_o(adc_done_i),
		.tx_cnt_o(ntx), .tx_last_o(ltx));

	task automatic conclude;
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	// one classic cycle; ack sampled at the edge, then released
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		v = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask : bus

	// poll the command field, bounded
	task automatic wait_idle;
		for (int k = 0; k < 60; k++) begin
			bus(0, ncs_pkg::OFF_CMD, 0);
			if (v[3:0] === 4'h0)
				break;
		end
		chk("cmd idle", v[3:0], 0);
	endtask : wait_idle

	// start configure on an empty fifo and pop the identity bytes
	task automatic readback(bit rnd);
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_CONFIG);
		wait_idle();
		for (int i = 0; i < 25; i++) begin
			bus(0, ncs_pkg::OFF_FIFO, 0);
			if (!(rnd && i inside {[2:4], [8:13], 24}))
				chk("id byte", v[7:0], i == 2 ? 8'h08 : i);
		end
	endtask : readback

	function automatic logic [15:0] crc(logic [15:0] s, logic [7:0] d);
		s ^= {d, 8'h00};
		repeat (8) s = s[15] ? (s << 1) ^ ncs_pkg::CRC_POLY : s << 1;
		return s;
	endfunction : crc

	initial begin
		clk_i = 0;
		forever #4 clk_i = ~clk_i;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		conclude();
	end

	initial begin
		{rst_i, clk_stable_i, wb_sel_i} = 6'h3f;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_IDLE);
		wait_idle();
		bus(0, ncs_pkg::OFF_EVENT, 0);
		chk("idle flag", v[4], 1);
		for (int i = 0; i < 25; i++)
			bus(1, ncs_pkg::OFF_FIFO, i);
		// load the identity buffer first, then read it back
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_CONFIG);
		wait_idle();
		bus(0, ncs_pkg::OFF_LEVEL, 0);
		chk("level", v, 0);
		readback(0);
		bus(0, ncs_pkg::OFF_STATUS, 0);
		chk("check byte", v[7:0], 8'h08 ^ 8'h03 ^ 8'h04);
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_RANDOM);
		wait_idle();
		readback(1);
		// crc with preset 1, then a late byte joins the sum
		bus(1, ncs_pkg::OFF_MODE, 1);
		bus(1, ncs_pkg::OFF_FIFO, 8'ha5);
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_CRC);
		bus(1, ncs_pkg::OFF_FIFO, 8'h3c);
		// power-down bit rides on the keep code; crc keeps running
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_KEEP | 32'h0000_0010);
		bus(0, ncs_pkg::OFF_CMD, 0);
		chk("crc running", {v[4:0], power_down_o}, 6'h27);
		c = crc(crc(ncs_pkg::CRC_PRE1, 8'ha5), 8'h3c);
		bus(0, ncs_pkg::OFF_CRC, 0);
		chk("crc", v[15:0], c);
		// leaving power-down reopens the bus only after the count
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_KEEP);
		bus(0, ncs_pkg::OFF_CMD, 0);
		chk("pd exit", {v[4:0], power_down_o}, 6'h06);
		bus(1, ncs_pkg::OFF_CMD, 4'h9);
		bus(0, ncs_pkg::OFF_CMD, 0);
		chk("unknown", v[3:0], 0);
		for (int i = 1; i < 4; i++)
			bus(1, ncs_pkg::OFF_FIFO, i);
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_TRANSMIT);
		wait_idle();
		chk("tx count", {ntx, ltx}, 16'h0303);
		bus(1, ncs_pkg::OFF_MODE, 32'h0000_0004);
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_CAL);
		wait_idle();
		chk("cal fine", cal_fine_o, 1);
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_ADC);
		wait_idle();
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_RECEIVE);
		wait_idle();
		bus(0, ncs_pkg::OFF_FIFO, 0);
		chk("rx byte", v[7:0], 8'h5a);
		// self test: eight generator bytes from a fixed seed
		bus(1, ncs_pkg::OFF_TEST, ncs_pkg::SELFTEST_CODE);
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_CRC);
		wait_idle();
		c = ncs_pkg::LFSR_SEED;
		for (int i = 0; i < 8; i++) begin
			bus(0, ncs_pkg::OFF_FIFO, 0);
			chk("self test", v[7:0], c[7:0]);
			c = {c[14:0], c[15] ^ c[13] ^ c[12] ^ c[10]};
		end
		// transceive holds its byte until the launch bit
		bus(1, ncs_pkg::OFF_FIFO, 8'h07);
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_TRX);
		bus(0, ncs_pkg::OFF_CMD, 0);
		chk("trx held", {v[3:0], ntx}, 12'hc03);
		bus(1, ncs_pkg::OFF_FRAMING, 32'h0000_0080);
		repeat (16) @(posedge clk_i);
		chk("trx sent", {ntx, ltx}, 16'h0407);
		bus(0, ncs_pkg::OFF_FIFO, 0);
		chk("trx rx", v[7:0], 8'h5a);
		// auto polling in card mode ends in transceive wait
		bus(1, ncs_pkg::OFF_MODE, 32'h0000_0008);
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_AUTO);
		repeat (16) @(posedge clk_i);
		bus(0, ncs_pkg::OFF_CMD, 0);
		chk("auto", v[3:0], ncs_pkg::CMD_TRX);
		bus(0, ncs_pkg::OFF_FIFO, 0);
		chk("auto rx", v[7:0], 8'h5a);
		bus(1, ncs_pkg::OFF_CMD, ncs_pkg::CMD_SRST);
		wait_idle();
		bus(0, ncs_pkg::OFF_MODE, 0);
		chk("mode reset", v[3:0], 0);
		readback(1);
		conclude();
	end
endmodule : test_ncs_command_sequencer

`default_nettype wire
